// [shared/srq_status_defs.vh]
/*
 * constants of the service request status byte block: bit positions,
 * reset values and the enable range limit.
 * assumes it is included by bare name from the design file.
 */
`ifndef SRQ_STATUS_DEFS_VH
`define SRQ_STATUS_DEFS_VH

// ***************************************************************
// status byte bit positions
// ***************************************************************
`define SB_BIT_HW1      0
`define SB_BIT_HW2      1
`define SB_BIT_UNUSED   2
`define SB_BIT_QUES     3
`define SB_BIT_MAV      4
`define SB_BIT_ESB      5
`define SB_BIT_RQS      6
`define SB_BIT_OPER     7

// ***************************************************************
// reset values, masks and limits
// ***************************************************************
`define SRE_RESET       8'h00
`define SRE_WRITE_MASK  8'hBF
`define SB_STB_MASK     8'hBB
`define SRE_MAX_VALUE   16'sh00FF
`define ERR_DATA_RANGE  16'shFF22

`endif

// [core/service_request_status_byte.v]
/*
 * status byte and service request logic of an instrument bus interface.
 * holds the six summary bits, the request service flag, the enable
 * register and the answers to the status byte and enable queries.
 * a small reducer module at the end folds each group to one bit.
 * assumes the lower status groups present event and enable words on the
 * same clock, and that the message parser delivers one-cycle command
 * strobes; answers go to the output queue as one-cycle data strobes.
 */
// Overview of operation
// RULE_01: bit 7 from operation, cdma, measuring groups
// RULE_02: bit 5 from standard event group
// RULE_03: bit 4 follows message available from queue
// RULE_04: bit 3 from questionable and calibration groups
// RULE_05: bit 1 from second hardware group
// RULE_06: bit 0 from hardware one, comms, serial groups
// RULE_07: summary is or of events and enables
// RULE_08: poll reads bit 6 as request service
// RULE_09: poll clears the request service flag
// RULE_10: poll leaves other summary bits alone
// RULE_11: query bit 6 is master summary status
// RULE_12: status query changes no bits
// RULE_13: status query queues value 0 to 255
// RULE_14: status byte is read only, summary driven
// RULE_15: clear status clears events except output queue
// RULE_16: bit 6 has no enable position
// RULE_17: enable query queues register unchanged
// RULE_18: request service when enabled bit set
// RULE_19: enable write keeps all but bit 6
// RULE_20: enable value outside 0 to 255 rejected, -222
// RULE_21: bit 2 always reads zero
`include "srq_status_defs.vh"

module service_request_status_byte #(
   parameter GROUP_WIDTH = 16
) (
   input  wire                   CORE_CLK_I,
   input  wire                   RST_B_I,
   input  wire [GROUP_WIDTH-1:0] OPER_EVENT_I,
   input  wire [GROUP_WIDTH-1:0] OPER_ENABLE_I,
   input  wire [GROUP_WIDTH-1:0] CDMA_EVENT_I,
   input  wire [GROUP_WIDTH-1:0] CDMA_ENABLE_I,
   input  wire [GROUP_WIDTH-1:0] MEAS_EVENT_I,
   input  wire [GROUP_WIDTH-1:0] MEAS_ENABLE_I,
   input  wire [GROUP_WIDTH-1:0] STDEV_EVENT_I,
   input  wire [GROUP_WIDTH-1:0] STDEV_ENABLE_I,
   input  wire                   MSG_AVAIL_I,
   input  wire [GROUP_WIDTH-1:0] QUES_EVENT_I,
   input  wire [GROUP_WIDTH-1:0] QUES_ENABLE_I,
   input  wire [GROUP_WIDTH-1:0] CAL_EVENT_I,
   input  wire [GROUP_WIDTH-1:0] CAL_ENABLE_I,
   input  wire [GROUP_WIDTH-1:0] HW2_EVENT_I,
   input  wire [GROUP_WIDTH-1:0] HW2_ENABLE_I,
   input  wire [GROUP_WIDTH-1:0] HW1_EVENT_I,
   input  wire [GROUP_WIDTH-1:0] HW1_ENABLE_I,
   input  wire [GROUP_WIDTH-1:0] COMM_EVENT_I,
   input  wire [GROUP_WIDTH-1:0] COMM_ENABLE_I,
   input  wire [GROUP_WIDTH-1:0] SER1_EVENT_I,
   input  wire [GROUP_WIDTH-1:0] SER1_ENABLE_I,
   input  wire [GROUP_WIDTH-1:0] SER2_EVENT_I,
   input  wire [GROUP_WIDTH-1:0] SER2_ENABLE_I,
   input  wire                   SERIAL_POLL_I,
   input  wire                   STB_QUERY_I,
   input  wire                   SRE_QUERY_I,
   input  wire                   SRE_WRITE_I,
   input  wire signed [15:0]     SRE_DATA_I,
   input  wire                   CLEAR_STATUS_I,
   output reg                    SRQ_O,
   output reg  [7:0]             POLL_BYTE_O,
   output reg                    POLL_VALID_O,
   output reg  [7:0]             QUEUE_DATA_O,
   output reg                    QUEUE_VALID_O,
   output reg                    ERROR_VALID_O,
   output reg  signed [15:0]     ERROR_CODE_O,
   output reg                    CLEAR_EVENTS_O,
   output reg  [7:0]             SUMMARY_O,
   output reg  [7:0]             ENABLE_O
);

   // ***************************************************************
   // summary bits
   // ***************************************************************

   // each group reduces to one bit: any enabled event true
   // names follow the group that each bit summarises
   wire oper_sum;
   wire cdma_sum;
   wire meas_sum;
   wire stdev_sum;
   wire ques_sum;
   wire cal_sum;
   wire hw2_sum;
   wire hw1_sum;
   wire comm_sum;
   wire ser1_sum;
   wire ser2_sum;

   // one reducer per group, all at the group width; a group that is
   // narrower in a later build can be padded with zero enables
   group_summary #(
      .WIDTH   (GROUP_WIDTH)
   ) u_oper_sum (
      .event_i (OPER_EVENT_I),
      .enable_i(OPER_ENABLE_I),
      .any_o   (oper_sum)
   );

   group_summary #(
      .WIDTH   (GROUP_WIDTH)
   ) u_cdma_sum (
      .event_i (CDMA_EVENT_I),
      .enable_i(CDMA_ENABLE_I),
      .any_o   (cdma_sum)
   );

   group_summary #(
      .WIDTH   (GROUP_WIDTH)
   ) u_meas_sum (
      .event_i (MEAS_EVENT_I),
      .enable_i(MEAS_ENABLE_I),
      .any_o   (meas_sum)
   );

   group_summary #(
      .WIDTH   (GROUP_WIDTH)
   ) u_stdev_sum (
      .event_i (STDEV_EVENT_I),
      .enable_i(STDEV_ENABLE_I),
      .any_o   (stdev_sum)
   );

   group_summary #(
      .WIDTH   (GROUP_WIDTH)
   ) u_ques_sum (
      .event_i (QUES_EVENT_I),
      .enable_i(QUES_ENABLE_I),
      .any_o   (ques_sum)
   );

   group_summary #(
      .WIDTH   (GROUP_WIDTH)
   ) u_cal_sum (
      .event_i (CAL_EVENT_I),
      .enable_i(CAL_ENABLE_I),
      .any_o   (cal_sum)
   );

   group_summary #(
      .WIDTH   (GROUP_WIDTH)
   ) u_hw2_sum (
      .event_i (HW2_EVENT_I),
      .enable_i(HW2_ENABLE_I),
      .any_o   (hw2_sum)
   );

   group_summary #(
      .WIDTH   (GROUP_WIDTH)
   ) u_hw1_sum (
      .event_i (HW1_EVENT_I),
      .enable_i(HW1_ENABLE_I),
      .any_o   (hw1_sum)
   );

   group_summary #(
      .WIDTH   (GROUP_WIDTH)
   ) u_comm_sum (
      .event_i (COMM_EVENT_I),
      .enable_i(COMM_ENABLE_I),
      .any_o   (comm_sum)
   );

   group_summary #(
      .WIDTH   (GROUP_WIDTH)
   ) u_ser1_sum (
      .event_i (SER1_EVENT_I),
      .enable_i(SER1_ENABLE_I),
      .any_o   (ser1_sum)
   );

   group_summary #(
      .WIDTH   (GROUP_WIDTH)
   ) u_ser2_sum (
      .event_i (SER2_EVENT_I),
      .enable_i(SER2_ENABLE_I),
      .any_o   (ser2_sum)
   );

   reg  [7:0] summary_next;
   reg  [7:0] summary_reg;
   reg  [7:0] enable_reg;
   reg        rqs_reg;
   reg        mss_prev_reg;

   // summary byte assembled; bit 6 is not a summary and stays zero here
   always @* begin
      summary_next                 = 8'h00;
      summary_next[`SB_BIT_OPER]   = oper_sum | cdma_sum | meas_sum;         // RULE_01
      summary_next[`SB_BIT_ESB]    = stdev_sum;                              // RULE_02
      summary_next[`SB_BIT_MAV]    = MSG_AVAIL_I;                            // RULE_03
      summary_next[`SB_BIT_QUES]   = ques_sum | cal_sum;                     // RULE_04
      summary_next[`SB_BIT_HW2]    = hw2_sum;                                // RULE_05
      summary_next[`SB_BIT_HW1]    = hw1_sum | comm_sum | ser1_sum | ser2_sum; // RULE_06
      summary_next[`SB_BIT_UNUSED] = 1'b0;                                   // RULE_21
   end

   // master summary: enabled summary bits, bit 6 masked from both sides
   wire mss = |(summary_reg & enable_reg & `SB_STB_MASK);  // RULE_11 RULE_16

   // ***************************************************************
   // registers
   // ***************************************************************

   // summary is never written by the controller, only follows sources
   always @(posedge CORE_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         summary_reg <= 8'h00;
      end else begin
         summary_reg <= summary_next;  // RULE_14
      end
   end

   // range check done on the signed value so negatives are caught too
   wire sre_in_range = (SRE_DATA_I >= 16'sh0000) && (SRE_DATA_I <= `SRE_MAX_VALUE);

   // enable register; bit 6 is always discarded on write
   always @(posedge CORE_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         enable_reg <= `SRE_RESET;
      end else if (SRE_WRITE_I && sre_in_range) begin
         enable_reg <= SRE_DATA_I[7:0] & `SRE_WRITE_MASK;  // RULE_19 RULE_20
      end
   end

   // request service flag: set on a rising master summary, cleared by
   // poll; a new cause in the poll cycle wins so it is never lost
   always @(posedge CORE_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         rqs_reg      <= 1'b0;
         mss_prev_reg <= 1'b0;
      end else begin
         mss_prev_reg <= mss;
         if (mss && !mss_prev_reg) begin
            rqs_reg <= 1'b1;        // RULE_18
         end else if (SERIAL_POLL_I) begin
            rqs_reg <= 1'b0;        // RULE_09
         end else if (!mss) begin
            rqs_reg <= 1'b0;        // cause gone, withdraw request
         end
      end
   end

   // ***************************************************************
   // answers to the controller
   // ***************************************************************

   // poll answer carries request service in bit 6, others untouched
   always @(posedge CORE_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         POLL_BYTE_O  <= 8'h00;
         POLL_VALID_O <= 1'b0;
      end else begin
         POLL_VALID_O <= SERIAL_POLL_I;
         if (SERIAL_POLL_I) begin
            POLL_BYTE_O <= (summary_reg & `SB_STB_MASK)
                           | {1'b0, rqs_reg, 6'b00_0000};  // RULE_08 RULE_10 RULE_21
         end
      end
   end

   // queries write one byte to the output queue; status query wins if
   // both arrive together, the enable query is then dropped
   always @(posedge CORE_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         QUEUE_DATA_O  <= 8'h00;
         QUEUE_VALID_O <= 1'b0;
      end else begin
         QUEUE_VALID_O <= STB_QUERY_I | SRE_QUERY_I;
         if (STB_QUERY_I) begin
            QUEUE_DATA_O <= (summary_reg & `SB_STB_MASK)
                            | {1'b0, mss, 6'b00_0000};  // RULE_11 RULE_12 RULE_13
         end else if (SRE_QUERY_I) begin
            QUEUE_DATA_O <= enable_reg;                  // RULE_17
         end
      end
   end

   // out of range enable value reported as data out of range
   always @(posedge CORE_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         ERROR_VALID_O <= 1'b0;
         ERROR_CODE_O  <= 16'sh0000;
      end else begin
         ERROR_VALID_O <= SRE_WRITE_I && !sre_in_range;  // RULE_20
         if (SRE_WRITE_I && !sre_in_range) begin
            ERROR_CODE_O <= `ERR_DATA_RANGE;
         end
      end
   end

   // clear status goes to the lower groups; queue and mav are spared
   // because message available is not part of this request
   always @(posedge CORE_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         CLEAR_EVENTS_O <= 1'b0;
      end else begin
         CLEAR_EVENTS_O <= CLEAR_STATUS_I;  // RULE_15
      end
   end

   // visible state and service request line
   always @(posedge CORE_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         SRQ_O     <= 1'b0;
         SUMMARY_O <= 8'h00;
         ENABLE_O  <= 8'h00;
      end else begin
         SRQ_O     <= rqs_reg;  // RULE_18
         SUMMARY_O <= summary_reg;
         ENABLE_O  <= enable_reg;
      end
   end

endmodule // service_request_status_byte

// ***************************************************************
// group reduction
// ***************************************************************

// one status group folded to its summary message. kept purely
// combinational so the summary register is the only cycle of
// latency between a group and the status byte; a wide group costs
// one or-tree here rather than a pipeline stage, which is cheap at
// the group widths in use
module group_summary #(
   parameter WIDTH = 16
) (
   input  wire [WIDTH-1:0] event_i,
   input  wire [WIDTH-1:0] enable_i,
   output wire             any_o
);

   // mask then reduce; a disabled event never reaches the byte
   assign any_o = |(event_i & enable_i);  // RULE_07

endmodule // group_summary

// [verif/srq_status_asserts.sv]
/* assertions on the status byte block ports.
   assumes binding by explicit named port connections onto the design top. */
module srq_status_asserts (
   input wire               CORE_CLK_I, RST_B_I, MSG_AVAIL_I, SERIAL_POLL_I, STB_QUERY_I,
   input wire               SRE_QUERY_I, SRE_WRITE_I, CLEAR_STATUS_I, SRQ_O, POLL_VALID_O,
   input wire               QUEUE_VALID_O, ERROR_VALID_O, CLEAR_EVENTS_O,
   input wire signed [15:0] SRE_DATA_I, ERROR_CODE_O,
   input wire [7:0]         POLL_BYTE_O, QUEUE_DATA_O, SUMMARY_O, ENABLE_O
);
   timeunit 1ns;
   timeprecision 1ns;
   // *****
   // properties
   // *****
   default clocking @(posedge CORE_CLK_I); endclocking
   default disable iff (!RST_B_I);
   // ports lag the internal registers by one, so mss here is one cycle late
   wire mss = |(SUMMARY_O & ENABLE_O & 8'hBF);
   wire bad_w = SRE_WRITE_I && (SRE_DATA_I < 0 || SRE_DATA_I > 255);
   property p_poll; SERIAL_POLL_I |=> POLL_VALID_O && (POLL_BYTE_O & 8'hBF) == SUMMARY_O; endproperty
   a_poll: assert property (p_poll) else $error("poll byte bits");
   property p_rqs; POLL_VALID_O |-> POLL_BYTE_O[6] == SRQ_O; endproperty
   a_rqs: assert property (p_rqs) else $error("poll bit 6");
   property p_rqs_clr; SERIAL_POLL_I ##1 ($stable(SUMMARY_O) && $stable(ENABLE_O)) |=> !SRQ_O; endproperty
   a_rqs_clr: assert property (p_rqs_clr) else $error("request kept after poll");
   property p_stb;
      STB_QUERY_I |=> QUEUE_VALID_O && QUEUE_DATA_O == {SUMMARY_O[7], mss, SUMMARY_O[5:0]};
   endproperty
   a_stb: assert property (p_stb) else $error("status query value");
   property p_sre_q; SRE_QUERY_I && !STB_QUERY_I |=> QUEUE_VALID_O && QUEUE_DATA_O == ENABLE_O; endproperty
   a_sre_q: assert property (p_sre_q) else $error("enable query value");
   property p_sre_w; SRE_WRITE_I && !bad_w |-> ##2 ENABLE_O == ($past(SRE_DATA_I[7:0], 2) & 8'hBF); endproperty
   a_sre_w: assert property (p_sre_w) else $error("enable write");
   property p_bad; bad_w |=> ERROR_VALID_O && ERROR_CODE_O == -16'sd222 ##1 $stable(ENABLE_O); endproperty
   a_bad: assert property (p_bad) else $error("range refusal");
   property p_clr; CLEAR_STATUS_I |=> CLEAR_EVENTS_O; endproperty
   a_clr: assert property (p_clr) else $error("clear not forwarded");
   property p_mav; $past(RST_B_I, 2) |-> SUMMARY_O[4] == $past(MSG_AVAIL_I, 2); endproperty
   a_mav: assert property (p_mav) else $error("message bit");
   property p_srq; $rose(SRQ_O) |-> $past(mss); endproperty
   a_srq: assert property (p_srq) else $error("request without cause");
   property p_fixed; !SUMMARY_O[2] && !SUMMARY_O[6] && !ENABLE_O[6]; endproperty
   a_fixed: assert property (p_fixed) else $error("fixed zero bits");
   c_poll: cover property (POLL_VALID_O && POLL_BYTE_O[6]);
   c_bad: cover property (bad_w);
   c_srq: cover property ($rose(SRQ_O));
endmodule // srq_status_asserts
bind service_request_status_byte srq_status_asserts u_chk (
   .CORE_CLK_I(CORE_CLK_I), .RST_B_I(RST_B_I), .MSG_AVAIL_I(MSG_AVAIL_I),
   .SERIAL_POLL_I(SERIAL_POLL_I), .STB_QUERY_I(STB_QUERY_I), .SRE_QUERY_I(SRE_QUERY_I),
   .SRE_WRITE_I(SRE_WRITE_I), .CLEAR_STATUS_I(CLEAR_STATUS_I), .SRQ_O(SRQ_O),
   .POLL_VALID_O(POLL_VALID_O), .QUEUE_VALID_O(QUEUE_VALID_O), .ERROR_VALID_O(ERROR_VALID_O),
   .CLEAR_EVENTS_O(CLEAR_EVENTS_O), .SRE_DATA_I(SRE_DATA_I), .ERROR_CODE_O(ERROR_CODE_O),
   .POLL_BYTE_O(POLL_BYTE_O), .QUEUE_DATA_O(QUEUE_DATA_O), .SUMMARY_O(SUMMARY_O),
   .ENABLE_O(ENABLE_O));

// [verif/bus_controller_model.sv]
/* active controller model: polls after a service request, slowly.
   assumes one clock shared with the block. */
module bus_controller_model (
   input  wire       clk_i, rst_b_i, srq_i, active_i, poll_valid_i,
   input  wire [7:0] poll_byte_i,
   output reg        poll_o,
   output reg  [7:0] last_byte_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // *****
   // poll engine
   // *****
   reg [1:0] wait_reg;
   // a slow answer: four edges of request before the poll goes out
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         poll_o <= 1'b0;
         wait_reg <= 2'h0;
         last_byte_o <= 8'h00;
      end else begin
         poll_o <= 1'b0;
         if (poll_valid_i) last_byte_o <= poll_byte_i;
         // the count restarts once the request is gone, so no stale wait
         if (active_i && srq_i) wait_reg <= wait_reg + 2'h1;
         else wait_reg <= 2'h0;
         if (active_i && srq_i && wait_reg == 2'h3) poll_o <= 1'b1;
      end
   end
endmodule // bus_controller_model

// [verif/service_request_status_byte_tb.sv]
/* self-checking bench of the status byte block.
   assumes the checker is bound and the controller model is compiled. */
module service_request_status_byte_tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int BIT_OF [11] = '{7, 7, 7, 5, 3, 3, 1, 0, 0, 0, 0};
   logic              clk = 1'b0, rst_b = 1'b0, mav = 1'b0, ctl_on = 1'b0;
   logic [15:0]       ev [11] = '{default: 16'h0000}, en [11] = '{default: 16'h0000};
   logic [4:0]        cmd = 5'h00;
   logic signed [15:0] wdata = 16'sh0000;
   wire               ctl_poll, srq, pvalid, qvalid, evalid, clr_ev;
   wire [7:0]         pbyte, qdata, summ, enab, ctl_byte;
   wire signed [15:0] ecode;
   int                n_errors = 0, tests_run = 0;
   always #5 clk = ~clk;
   service_request_status_byte DUT (.CORE_CLK_I(clk), .RST_B_I(rst_b),
      .OPER_EVENT_I(ev[0]), .OPER_ENABLE_I(en[0]), .CDMA_EVENT_I(ev[1]), .CDMA_ENABLE_I(en[1]),
      .MEAS_EVENT_I(ev[2]), .MEAS_ENABLE_I(en[2]), .STDEV_EVENT_I(ev[3]), .STDEV_ENABLE_I(en[3]),
      .QUES_EVENT_I(ev[4]), .QUES_ENABLE_I(en[4]), .CAL_EVENT_I(ev[5]), .CAL_ENABLE_I(en[5]),
      .HW2_EVENT_I(ev[6]), .HW2_ENABLE_I(en[6]), .HW1_EVENT_I(ev[7]), .HW1_ENABLE_I(en[7]),
      .COMM_EVENT_I(ev[8]), .COMM_ENABLE_I(en[8]), .SER1_EVENT_I(ev[9]), .SER1_ENABLE_I(en[9]),
      .SER2_EVENT_I(ev[10]), .SER2_ENABLE_I(en[10]), .MSG_AVAIL_I(mav),
      .SERIAL_POLL_I(cmd[0] | ctl_poll), .STB_QUERY_I(cmd[1]), .SRE_QUERY_I(cmd[2]),
      .SRE_WRITE_I(cmd[3]), .SRE_DATA_I(wdata), .CLEAR_STATUS_I(cmd[4]), .SRQ_O(srq),
      .POLL_BYTE_O(pbyte), .POLL_VALID_O(pvalid), .QUEUE_DATA_O(qdata), .QUEUE_VALID_O(qvalid),
      .ERROR_VALID_O(evalid), .ERROR_CODE_O(ecode), .CLEAR_EVENTS_O(clr_ev),
      .SUMMARY_O(summ), .ENABLE_O(enab));
   bus_controller_model ctl (.clk_i(clk), .rst_b_i(rst_b), .srq_i(srq), .active_i(ctl_on),
      .poll_valid_i(pvalid), .poll_byte_i(pbyte), .poll_o(ctl_poll), .last_byte_o(ctl_byte));
   // *****
   // tasks
   // *****
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one strobe, sampled just after the edge where the answer lands
   task automatic go(input logic [4:0] c, input logic signed [15:0] d);
      @(posedge clk) cmd <= c;
      wdata <= d;
      @(posedge clk) cmd <= 5'h00;
      #1;
   endtask
   // summary reaches the ports two edges after its inputs
   task automatic settle;
      repeat (4) @(posedge clk);
      #1;
   endtask
   task automatic give_verdict;
      if (n_errors == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      #20000;
      n_errors++;
      give_verdict;
   end
   // *****
   // tests
   // *****
   initial begin
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      // each group alone, then with its enable on another bit
      for (int g = 0; g < 11; g++) begin
         @(posedge clk) ev[g] <= 16'h0001 << g;
         en[g] <= 16'h0001 << g;
         settle;
         chk(summ, 8'h01 << BIT_OF[g]);
         @(posedge clk) en[g] <= 16'h0002 << g;
         settle;
         chk(summ, 16'h0000);
         @(posedge clk) ev[g] <= 16'h0000;
      end
      go(5'h08, 16'sh00FF);
      settle;
      chk(enab, 16'h00BF);
      go(5'h08, 16'sh012C);
      chk({evalid, ecode[14:0]}, 16'hFF22);
      chk(ecode, 16'hFF22);
      go(5'h08, -16'sd1);
      chk({evalid, ecode[14:0]}, 16'hFF22);
      go(5'h08, 16'sd18);
      @(posedge clk) mav <= 1'b1;
      settle;
      chk({srq, enab, summ[6:0]}, 16'h8910);
      go(5'h02, 16'sh0000);
      chk({qvalid, qdata}, 16'h0150);
      go(5'h01, 16'sh0000);
      chk({pvalid, pbyte}, 16'h0150);
      go(5'h01, 16'sh0000);
      chk(pbyte, 16'h0010);
      go(5'h02, 16'sh0000);
      chk({qdata, summ}, 16'h5010);
      go(5'h04, 16'sh0000);
      chk(qdata, 16'h0012);
      // both queries together: the status answer is the one queued
      go(5'h06, 16'sh0000);
      chk(qdata, 16'h0050);
      go(5'h10, 16'sh0000);
      chk(clr_ev, 16'h0001);
      settle;
      chk(summ, 16'h0010);
      // the controller model answers this one
      go(5'h08, 16'sd32);
      @(posedge clk) ctl_on <= 1'b1;
      ev[3] <= 16'h0004;
      en[3] <= 16'h0004;
      repeat (14) @(posedge clk);
      #1;
      chk({srq, ctl_byte}, 16'h0070);
      give_verdict;
   end
endmodule // service_request_status_byte_tb
